// ==== src/sci_fifo.sv ====
`timescale 1ns/10ps
`default_nettype none
module sci_fifo #(
    parameter int W = 9,
    parameter int D = 16
) (
    input wire logic core_clk,
    input wire logic nrst,
    sci_fifo_if.fifo f
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem_ff [D];
    logic [AW-1:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
    logic [AW:0] cnt_ff, nxt_cnt;
    logic push, pop;

    assign f.push_ready = (cnt_ff != (AW+1)'(D));
    assign f.pop_valid = (cnt_ff != '0);
    assign f.pop_data = mem_ff[rd_ff];
    assign push = f.push_valid && f.push_ready && !f.flush;
    assign pop = f.pop_valid && f.pop_ready && !f.flush;

    always_comb begin
        nxt_wr = wr_ff;
        nxt_rd = rd_ff;
        nxt_cnt = cnt_ff;
        if (f.flush) begin
            nxt_wr = '0;
            nxt_rd = '0;
            nxt_cnt = '0;
        end else begin
            if (push) nxt_wr = AW'(wr_ff + 1'b1);
            if (pop) nxt_rd = AW'(rd_ff + 1'b1);
            nxt_cnt = (AW+1)'(cnt_ff + push - pop);
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            wr_ff <= '0;
            rd_ff <= '0;
            cnt_ff <= '0;
        end else begin
            wr_ff <= nxt_wr;
            rd_ff <= nxt_rd;
            cnt_ff <= nxt_cnt;
        end
    end

    // Storage needs no reset; empty flag guards stale words
    always_ff @(posedge core_clk) begin
        if (push) mem_ff[wr_ff] <= f.push_data;
    end

    fifo_bound_a: assert property (@(posedge core_clk) disable iff (!nrst) cnt_ff <= (AW+1)'(D))
        else $error("fifo count above depth");
endmodule : sci_fifo
`default_nettype wire

// ==== src/sci_fifo_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface sci_fifo_if #(parameter int W = 9);
    logic push_valid;
    logic push_ready;
    logic [W-1:0] push_data;
    logic pop_valid;
    logic pop_ready;
    logic [W-1:0] pop_data;
    logic flush;
    modport producer (output push_valid, output push_data, input push_ready,
                      input pop_valid, input pop_data, output pop_ready, output flush);
    modport fifo (input push_valid, input push_data, output push_ready,
                  output pop_valid, output pop_data, input pop_ready, input flush);
endinterface : sci_fifo_if
`default_nettype wire

// ==== src/sci_pkg.sv ====
package sci_pkg;
    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CONTROL_WORD_B = 8'h04;
    localparam logic [7:0] OFS_BIT_RATE_DIVIDER = 8'h0c;
    localparam logic [7:0] OFS_IRQ_ENABLE_CLEAR = 8'h14;
    localparam logic [7:0] OFS_IRQ_ENABLE_SET = 8'h16;
    localparam logic [7:0] OFS_IRQ_FLAGS = 8'h18;
    localparam logic [7:0] OFS_DATA = 8'h28;

    // ------------------------------------------------------------
    // Control word B field positions
    // ------------------------------------------------------------
    localparam int CWB_RXEN = 17;
    localparam int CWB_SLAVE_ADDRESS_MATCH_MODE_HI = 15;
    localparam int CWB_SLAVE_ADDRESS_MATCH_MODE_LO = 14;
    localparam int CWB_HW_CHIP_SELECT_ENABLE = 13;
    localparam int CWB_SELECT_LOW_DETECT_ENABLE = 9;
    localparam int CWB_SLAVE_PRELOAD_ENABLE = 6;
    localparam int CWB_CHARACTER_WIDTH_HI = 2;

    // ------------------------------------------------------------
    // Interrupt bit positions, shared by enables and flags
    // ------------------------------------------------------------
    localparam int IRQ_ERROR = 7;
    localparam int IRQ_SSL = 3;
    localparam int IRQ_RXC = 2;
    localparam int IRQ_TXC = 1;
    localparam int IRQ_DRE = 0;
    localparam logic [7:0] IRQ_IMPL_MASK = 8'h8f;

    // ------------------------------------------------------------
    // Reset values and sizes
    // ------------------------------------------------------------
    localparam logic [31:0] CWB_RESET = 32'h0000_0000;
    localparam logic [7:0] BAUD_RESET = 8'h00;
    localparam logic [7:0] IRQ_EN_RESET = 8'h00;
    localparam int CHAR_W = 9;
    localparam int RX_FIFO_DEPTH = 16;

    typedef enum logic [1:0] {
        AM_MASK = 2'h0,
        AM_DUAL_ADDRESS_MATCH = 2'h1,
        AM_RANGE = 2'h2,
        AM_RESERVED = 2'h3
    } sci_slave_address_match_mode_t;

    typedef enum logic [2:0] {
        CW_8BIT = 3'h0,
        CW_9BIT = 3'h1
    } sci_chwidth_t;
endpackage : sci_pkg

// ==== src/sci_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module sci_top (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    input wire logic master_mode,
    input wire logic addressed_frame,
    input wire logic [7:0] match_address,
    input wire logic [7:0] match_mask_or_second_value,
    input wire logic ss_pin,
    input wire logic xfer_busy,
    input wire logic rx_valid,
    input wire logic [sci_pkg::CHAR_W-1:0] rx_data,
    input wire logic first_byte_valid,
    input wire logic [7:0] first_byte,
    input wire logic tx_take,
    input wire logic tx_shift_done,
    output logic rx_ready,
    output logic [sci_pkg::CHAR_W-1:0] tx_data,
    output logic tx_valid,
    output logic preload_stb,
    output logic addr_match,
    output logic addr_match_stb,
    output logic ss_out,
    output logic ss_oe_n,
    output logic wake_stb,
    output logic [7:0] bit_rate_divider,
    output logic rx_enable,
    output logic irq
);
    import sci_pkg::*;

    // ------------------------------------------------------------
    // Register file state
    // ------------------------------------------------------------
    logic [1:0] slave_address_match_mode_ff, nxt_slave_address_match_mode;
    logic hw_chip_select_enable_ff, nxt_hw_chip_select_enable, select_low_detect_enable_ff, nxt_select_low_detect_enable, slave_preload_enable_ff, nxt_slave_preload_enable, rxen_ff, nxt_rxen;
    logic [2:0] character_width_ff, nxt_character_width;
    logic [7:0] baud_ff, nxt_baud, irq_en_ff, nxt_irq_en;
    logic err_ff, nxt_err, ssl_ff, nxt_ssl, txc_ff, nxt_txc;
    logic [CHAR_W-1:0] txd_ff, nxt_txd;
    logic txp_ff, nxt_txp, pload_ff, nxt_pload;
    logic [31:0] rdata_ff, nxt_rdata;
    logic irq_ff, nxt_irq, rdy_ff;
    logic [2:0] ss_sync_ff;
    logic match_ff, nxt_match, mstb_ff, nxt_mstb;
    logic ss_out_ff, nxt_ss_out, ss_oe_n_ff, nxt_ss_oe_n, wake_ff, nxt_wake;
    logic [7:0] flags, raw_match_addr;
    logic wr_cwb, wr_clr, wr_set, wr_flag, wr_data, rd_data, ss_fall, overrun, is_match;
    logic [CHAR_W-1:0] char_mask;

    sci_fifo_if #(.W(CHAR_W)) rxq ();

    sci_fifo #(.W(CHAR_W), .D(RX_FIFO_DEPTH)) u_rx_fifo (
        .core_clk(core_clk),
        .nrst(nrst),
        .f(rxq)
    );

    // ------------------------------------------------------------
    // Decode and data path
    // ------------------------------------------------------------
    assign wr_cwb = reg_wr && (reg_addr == OFS_CONTROL_WORD_B);
    assign wr_clr = reg_wr && (reg_addr == OFS_IRQ_ENABLE_CLEAR);
    assign wr_set = reg_wr && (reg_addr == OFS_IRQ_ENABLE_SET);
    assign wr_flag = reg_wr && (reg_addr == OFS_IRQ_FLAGS);
    assign wr_data = reg_wr && (reg_addr == OFS_DATA);
    assign rd_data = reg_rd && (reg_addr == OFS_DATA);
    assign char_mask = (character_width_ff == CW_9BIT) ? 9'h1ff : 9'h0ff;

    // Overrun judged on live fullness; the registered ready may lag one cycle
    assign overrun = rx_valid && rxen_ff && !rxq.push_ready;
    assign rxq.push_valid = rx_valid && rxen_ff;
    assign rxq.push_data = rx_data & char_mask;
    assign rxq.pop_ready = rd_data;
    assign rxq.flush = !rxen_ff;

    assign ss_fall = ss_sync_ff[2] && !ss_sync_ff[1];
    assign flags = {err_ff, 3'h0, ssl_ff, rxq.pop_valid, txc_ff, !txp_ff};

    always_comb begin
        raw_match_addr = match_address;
        is_match = 1'b0;
        unique case (sci_slave_address_match_mode_t'(slave_address_match_mode_ff))
            AM_MASK: is_match = ((first_byte ^ raw_match_addr) & ~match_mask_or_second_value) == 8'h00;
            AM_DUAL_ADDRESS_MATCH: is_match = (first_byte == raw_match_addr)
                                           || (first_byte == match_mask_or_second_value);
            AM_RANGE: is_match = (first_byte <= raw_match_addr)
                              && (first_byte >= match_mask_or_second_value);
            AM_RESERVED: is_match = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        nxt_slave_address_match_mode = slave_address_match_mode_ff;
        nxt_hw_chip_select_enable = hw_chip_select_enable_ff;
        nxt_select_low_detect_enable = select_low_detect_enable_ff;
        nxt_slave_preload_enable = slave_preload_enable_ff;
        nxt_rxen = rxen_ff;
        nxt_character_width = character_width_ff;
        nxt_baud = baud_ff;
        nxt_irq_en = irq_en_ff;
        nxt_err = err_ff;
        nxt_ssl = ssl_ff;
        nxt_txc = txc_ff;
        nxt_txd = txd_ff;
        nxt_txp = txp_ff;
        nxt_pload = 1'b0;
        nxt_rdata = 32'h0000_0000;
        if (wr_cwb) begin
            nxt_slave_address_match_mode = reg_wdata[CWB_SLAVE_ADDRESS_MATCH_MODE_HI:CWB_SLAVE_ADDRESS_MATCH_MODE_LO];
            nxt_hw_chip_select_enable = reg_wdata[CWB_HW_CHIP_SELECT_ENABLE];
            nxt_select_low_detect_enable = reg_wdata[CWB_SELECT_LOW_DETECT_ENABLE];
            nxt_slave_preload_enable = reg_wdata[CWB_SLAVE_PRELOAD_ENABLE];
            nxt_rxen = reg_wdata[CWB_RXEN];
            nxt_character_width = reg_wdata[CWB_CHARACTER_WIDTH_HI:0];
        end
        if (reg_wr && reg_addr == OFS_BIT_RATE_DIVIDER) nxt_baud = reg_wdata[7:0];
        if (wr_clr) nxt_irq_en = irq_en_ff & ~(reg_wdata[7:0] & IRQ_IMPL_MASK);
        if (wr_set) nxt_irq_en = irq_en_ff | (reg_wdata[7:0] & IRQ_IMPL_MASK);
        // Clear first, set after: an event in the clearing cycle survives
        if (wr_flag && reg_wdata[IRQ_ERROR]) nxt_err = 1'b0;
        if (overrun) nxt_err = 1'b1;
        if (wr_flag && reg_wdata[IRQ_SSL]) nxt_ssl = 1'b0;
        if (ss_fall && !master_mode && select_low_detect_enable_ff) nxt_ssl = 1'b1;
        if ((wr_flag && reg_wdata[IRQ_TXC]) || wr_data) nxt_txc = 1'b0;
        if (master_mode && tx_shift_done && !txp_ff) nxt_txc = 1'b1;
        if (tx_take) nxt_txp = 1'b0;
        if (wr_data) begin
            nxt_txd = reg_wdata[CHAR_W-1:0] & char_mask;
            // Preload needs select high and an idle shifter
            if (slave_preload_enable_ff && !master_mode && ss_sync_ff[1] && !xfer_busy) begin
                nxt_pload = 1'b1;
                nxt_txp = 1'b0;
            end else begin
                nxt_txp = 1'b1;
            end
        end
        if (reg_rd) begin
            unique case (reg_addr)
                OFS_CONTROL_WORD_B: nxt_rdata = {14'h0, rxen_ff, 1'b0, slave_address_match_mode_ff, hw_chip_select_enable_ff, 3'h0, select_low_detect_enable_ff,
                                                 2'h0, slave_preload_enable_ff, 3'h0, character_width_ff};
                OFS_BIT_RATE_DIVIDER: nxt_rdata = {24'h0, baud_ff};
                OFS_IRQ_ENABLE_CLEAR, OFS_IRQ_ENABLE_SET: nxt_rdata = {24'h0, irq_en_ff};
                OFS_IRQ_FLAGS: nxt_rdata = {24'h0, flags};
                OFS_DATA: nxt_rdata = {23'h0, rxq.pop_data};
                default: nxt_rdata = 32'h0000_0000;
            endcase
        end
        nxt_irq = |(flags & irq_en_ff);
        nxt_match = match_ff;
        nxt_mstb = 1'b0;
        if (first_byte_valid && addressed_frame && !master_mode) begin
            nxt_match = is_match;
            nxt_mstb = 1'b1;
        end
        nxt_ss_oe_n = !(hw_chip_select_enable_ff && master_mode);
        nxt_ss_out = !(hw_chip_select_enable_ff && master_mode && (xfer_busy || txp_ff));
        nxt_wake = ss_fall && select_low_detect_enable_ff;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            slave_address_match_mode_ff <= CWB_RESET[CWB_SLAVE_ADDRESS_MATCH_MODE_HI:CWB_SLAVE_ADDRESS_MATCH_MODE_LO];
            hw_chip_select_enable_ff <= CWB_RESET[CWB_HW_CHIP_SELECT_ENABLE];
            select_low_detect_enable_ff <= CWB_RESET[CWB_SELECT_LOW_DETECT_ENABLE];
            slave_preload_enable_ff <= CWB_RESET[CWB_SLAVE_PRELOAD_ENABLE];
            rxen_ff <= CWB_RESET[CWB_RXEN];
            character_width_ff <= CWB_RESET[CWB_CHARACTER_WIDTH_HI:0];
            baud_ff <= BAUD_RESET;
            irq_en_ff <= IRQ_EN_RESET;
            err_ff <= 1'b0;
            ssl_ff <= 1'b0;
            txc_ff <= 1'b0;
            txd_ff <= '0;
            txp_ff <= 1'b0;
            pload_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            irq_ff <= 1'b0;
            rdy_ff <= 1'b0;
            ss_sync_ff <= 3'h7;
            match_ff <= 1'b0;
            mstb_ff <= 1'b0;
            ss_out_ff <= 1'b1;
            ss_oe_n_ff <= 1'b1;
            wake_ff <= 1'b0;
        end else begin
            slave_address_match_mode_ff <= nxt_slave_address_match_mode;
            hw_chip_select_enable_ff <= nxt_hw_chip_select_enable;
            select_low_detect_enable_ff <= nxt_select_low_detect_enable;
            slave_preload_enable_ff <= nxt_slave_preload_enable;
            rxen_ff <= nxt_rxen;
            character_width_ff <= nxt_character_width;
            baud_ff <= nxt_baud;
            irq_en_ff <= nxt_irq_en;
            err_ff <= nxt_err;
            ssl_ff <= nxt_ssl;
            txc_ff <= nxt_txc;
            txd_ff <= nxt_txd;
            txp_ff <= nxt_txp;
            pload_ff <= nxt_pload;
            rdata_ff <= nxt_rdata;
            irq_ff <= nxt_irq;
            // Ready to the engine is advisory; a late char still counts as overrun
            rdy_ff <= rxq.push_ready;
            ss_sync_ff <= {ss_sync_ff[1], ss_sync_ff[0], ss_pin};
            match_ff <= nxt_match;
            mstb_ff <= nxt_mstb;
            ss_out_ff <= nxt_ss_out;
            ss_oe_n_ff <= nxt_ss_oe_n;
            wake_ff <= nxt_wake;
        end
    end

    assign reg_rdata = rdata_ff;
    assign rx_ready = rdy_ff;
    assign tx_data = txd_ff;
    assign tx_valid = txp_ff;
    assign preload_stb = pload_ff;
    assign addr_match = match_ff;
    assign addr_match_stb = mstb_ff;
    assign ss_out = ss_out_ff;
    assign ss_oe_n = ss_oe_n_ff;
    assign wake_stb = wake_ff;
    assign bit_rate_divider = baud_ff;
    assign rx_enable = rxen_ff;
    assign irq = irq_ff;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    err_sticky_a: assert property (overrun |=> err_ff)
        else $error("overrun did not set error flag");
    err_hold_a: assert property (err_ff && !(wr_flag && reg_wdata[IRQ_ERROR]) |=> err_ff)
        else $error("error flag dropped without clear");
    en_set_a: assert property (wr_set && !wr_clr |=> ((irq_en_ff & $past(reg_wdata[7:0]) & IRQ_IMPL_MASK)
                                                      == ($past(reg_wdata[7:0]) & IRQ_IMPL_MASK)))
        else $error("enable set failed");
    en_clr_a: assert property (wr_clr |=> ((irq_en_ff & $past(reg_wdata[7:0])) == 8'h00))
        else $error("enable clear failed");
    en_rsvd_a: assert property ((irq_en_ff & ~IRQ_IMPL_MASK) == 8'h00)
        else $error("reserved enable bit set");
    irq_map_a: assert property (1'b1 |=> irq_ff == (|($past(flags) & $past(irq_en_ff))))
        else $error("interrupt request mismatch");
    ssl_set_a: assert property (ss_fall && !master_mode && select_low_detect_enable_ff |=> ssl_ff)
        else $error("select-low flag not set");
    ss_drive_a: assert property (hw_chip_select_enable_ff && master_mode && xfer_busy |=> !ss_out_ff && !ss_oe_n_ff)
        else $error("hardware select not driven");
    master_match_a: assert property (master_mode |=> !mstb_ff)
        else $error("address match in master mode");
    preload_a: assert property (wr_data && slave_preload_enable_ff && !master_mode && ss_sync_ff[1] && !xfer_busy
                                |=> preload_stb && !txp_ff)
        else $error("preload did not occur");
    baud_a: assert property (reg_wr && reg_addr == OFS_BIT_RATE_DIVIDER |=> baud_ff == $past(reg_wdata[7:0]))
        else $error("divider not written");
    rxc_a: assert property (rx_valid && rxen_ff && rxq.push_ready |=> flags[IRQ_RXC])
        else $error("receive-done not set after push");

    ovf_c: cover property (overrun ##1 err_ff);
    pload_c: cover property (preload_stb);
    match_c: cover property (addr_match_stb && addr_match);
    irq_c: cover property (irq_ff);
    wake_c: cover property (wake_stb);
endmodule : sci_top
`default_nettype wire

// ==== tb/sci_far_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module sci_far_model (
    input wire logic core_clk,
    input wire logic rx_ready,
    input wire logic tx_valid,
    output logic ss_pin,
    output logic xfer_busy,
    output logic rx_valid,
    output logic [sci_pkg::CHAR_W-1:0] rx_data,
    output logic first_byte_valid,
    output logic [7:0] first_byte,
    output logic tx_take,
    output logic tx_shift_done
);
    import sci_pkg::*;
    // ------------------------------------------------------------
    // Shift engine and serial side stand-in
    // ------------------------------------------------------------
    initial begin
        ss_pin = 1'b1;
        xfer_busy = 1'b0;
        rx_valid = 1'b0;
        rx_data = 9'h155;
        first_byte_valid = 1'b0;
        first_byte = 8'haa;
        tx_take = 1'b0;
        tx_shift_done = 1'b0;
    end

    // Idle data lines show the inverse so a stale value never passes
    task automatic send_char(input logic [CHAR_W-1:0] c, input logic ignore_ready);
        int n;
        n = 0;
        while (!ignore_ready && rx_ready !== 1'b1 && n < 100) begin
            @(posedge core_clk);
            n++;
        end
        @(posedge core_clk);
        rx_valid <= 1'b1;
        rx_data <= c;
        @(posedge core_clk);
        rx_valid <= 1'b0;
        rx_data <= ~c;
    endtask : send_char

    task automatic frame_byte(input logic [7:0] b);
        @(posedge core_clk);
        first_byte_valid <= 1'b1;
        first_byte <= b;
        @(posedge core_clk);
        first_byte_valid <= 1'b0;
        first_byte <= ~b;
    endtask : frame_byte

    task automatic select(input logic lvl);
        @(posedge core_clk);
        ss_pin <= lvl;
    endtask : select

    task automatic shift_out();
        int n;
        n = 0;
        while (tx_valid !== 1'b1 && n < 100) begin
            @(posedge core_clk);
            n++;
        end
        @(posedge core_clk);
        tx_take <= 1'b1;
        xfer_busy <= 1'b1;
        @(posedge core_clk);
        tx_take <= 1'b0;
        repeat (8) @(posedge core_clk);
        tx_shift_done <= 1'b1;
        @(posedge core_clk);
        tx_shift_done <= 1'b0;
        xfer_busy <= 1'b0;
    endtask : shift_out
endmodule : sci_far_model
`default_nettype wire

// ==== tb/tb_sci_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_sci_top;
    import sci_pkg::*;
    logic core_clk, nrst, reg_wr, reg_rd, master_mode, addressed_frame;
    logic [7:0] reg_addr, match_address, match_mask_or_second_value, first_byte, bit_rate_divider;
    logic [31:0] reg_wdata, reg_rdata;
    logic ss_pin, xfer_busy, rx_valid, first_byte_valid, tx_take, tx_shift_done, rx_ready, tx_valid;
    logic preload_stb, addr_match, addr_match_stb, ss_out, ss_oe_n, wake_stb, rx_enable, irq;
    logic [CHAR_W-1:0] rx_data, tx_data;
    int error_cnt = 0;
    int check_count = 0;

    sci_top uut (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .master_mode(master_mode),
        .addressed_frame(addressed_frame), .match_address(match_address),
        .match_mask_or_second_value(match_mask_or_second_value), .ss_pin(ss_pin), .xfer_busy(xfer_busy),
        .rx_valid(rx_valid), .rx_data(rx_data), .first_byte_valid(first_byte_valid), .first_byte(first_byte),
        .tx_take(tx_take), .tx_shift_done(tx_shift_done), .rx_ready(rx_ready), .tx_data(tx_data),
        .tx_valid(tx_valid), .preload_stb(preload_stb), .addr_match(addr_match), .addr_match_stb(addr_match_stb),
        .ss_out(ss_out), .ss_oe_n(ss_oe_n), .wake_stb(wake_stb), .bit_rate_divider(bit_rate_divider),
        .rx_enable(rx_enable), .irq(irq));
    sci_far_model far (.core_clk(core_clk), .rx_ready(rx_ready), .tx_valid(tx_valid), .ss_pin(ss_pin),
        .xfer_busy(xfer_busy), .rx_valid(rx_valid), .rx_data(rx_data), .first_byte_valid(first_byte_valid),
        .first_byte(first_byte), .tx_take(tx_take), .tx_shift_done(tx_shift_done));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // ------------------------------------------------------------
    // Bus cycles and compares
    // ------------------------------------------------------------
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t value got %h expected %h", $time, got, exp);
        end
    endtask : chk32

    task automatic chk1(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t bit got %b expected %b", $time, got, exp);
        end
    endtask : chk1

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        chk32(reg_rdata, exp);
    endtask : rchk

    task automatic settle();
        @(posedge core_clk);
        #1;
    endtask : settle

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        rchk(OFS_CONTROL_WORD_B, 32'h0);
        rchk(OFS_BIT_RATE_DIVIDER, 32'h0);
        rchk(OFS_IRQ_FLAGS, 32'h01);
        rchk(8'h30, 32'h0);
        chk1(irq, 1'b0);
        wr(OFS_BIT_RATE_DIVIDER, 32'ha5);
        wr(8'h30, 32'hff);
        rchk(OFS_BIT_RATE_DIVIDER, 32'ha5);
        chk32({24'h0, bit_rate_divider}, 32'ha5);
        wr(OFS_CONTROL_WORD_B, 32'h0002_e241);
        rchk(OFS_CONTROL_WORD_B, 32'h0002_e241);
        wr(OFS_CONTROL_WORD_B, 32'h0);
        $display("regs done");
    endtask : t_regs

    task automatic t_enables();
        rchk(OFS_IRQ_ENABLE_SET, 32'h0);
        wr(OFS_IRQ_ENABLE_SET, 32'h8f);
        rchk(OFS_IRQ_ENABLE_CLEAR, 32'h8f);
        wr(OFS_IRQ_ENABLE_CLEAR, 32'h05);
        rchk(OFS_IRQ_ENABLE_SET, 32'h8a);
        wr(OFS_IRQ_ENABLE_SET, 32'h00);
        rchk(OFS_IRQ_ENABLE_CLEAR, 32'h8a);
        wr(OFS_IRQ_ENABLE_CLEAR, 32'h8a);
        rchk(OFS_IRQ_ENABLE_SET, 32'h0);
        wr(OFS_IRQ_ENABLE_SET, 32'h01);
        settle();
        chk1(irq, 1'b1);
        wr(OFS_IRQ_ENABLE_CLEAR, 32'h01);
        settle();
        chk1(irq, 1'b0);
        $display("enables done");
    endtask : t_enables

    task automatic t_ssl(input logic en, input logic [31:0] exp);
        logic seen;
        seen = 1'b0;
        wr(OFS_CONTROL_WORD_B, {22'h0, en, 9'h0});
        far.select(1'b0);
        repeat (10) begin
            settle();
            if (wake_stb === 1'b1) seen = 1'b1;
        end
        chk1(seen, en);
        rchk(OFS_IRQ_FLAGS, exp);
        wr(OFS_IRQ_FLAGS, 32'h08);
        rchk(OFS_IRQ_FLAGS, 32'h01);
        far.select(1'b1);
        repeat (4) settle();
        $display("select low done");
    endtask : t_ssl

    task automatic t_rx();
        wr(OFS_CONTROL_WORD_B, 32'h0002_0000);
        chk1(rx_enable, 1'b1);
        far.send_char(9'h03c, 1'b0);
        rchk(OFS_IRQ_FLAGS, 32'h05);
        rchk(OFS_DATA, 32'h03c);
        rchk(OFS_IRQ_FLAGS, 32'h01);
        for (int i = 0; i < RX_FIFO_DEPTH; i++) far.send_char(9'(i + 16), 1'b0);
        repeat (2) settle();
        chk1(rx_ready, 1'b0);
        far.send_char(9'h0ff, 1'b1);
        rchk(OFS_IRQ_FLAGS, 32'h85);
        wr(OFS_IRQ_FLAGS, 32'h00);
        rchk(OFS_IRQ_FLAGS, 32'h85);
        wr(OFS_IRQ_FLAGS, 32'h80);
        rchk(OFS_IRQ_FLAGS, 32'h05);
        for (int i = 0; i < RX_FIFO_DEPTH; i++) rchk(OFS_DATA, 32'(i + 16));
        rchk(OFS_IRQ_FLAGS, 32'h01);
        far.send_char(9'h011, 1'b0);
        wr(OFS_CONTROL_WORD_B, 32'h0);
        chk1(rx_enable, 1'b0);
        rchk(OFS_IRQ_FLAGS, 32'h01);
        $display("receive done");
    endtask : t_rx

    task automatic match_case(input logic mm, input logic [1:0] mode, input logic [7:0] second,
                              input logic [7:0] b, input logic exp_stb, input logic exp_m);
        @(posedge core_clk);
        master_mode <= mm;
        match_mask_or_second_value <= second;
        wr(OFS_CONTROL_WORD_B, {16'h0, mode, 14'h0});
        far.frame_byte(b);
        #1;
        chk1(addr_match_stb, exp_stb);
        if (exp_stb) chk1(addr_match, exp_m);
    endtask : match_case

    task automatic t_match();
        match_case(1'b0, 2'h0, 8'h0f, 8'h4a, 1'b1, 1'b1);
        match_case(1'b0, 2'h0, 8'h0f, 8'h5a, 1'b1, 1'b0);
        match_case(1'b0, 2'h1, 8'h22, 8'h22, 1'b1, 1'b1);
        match_case(1'b0, 2'h1, 8'h22, 8'h40, 1'b1, 1'b1);
        match_case(1'b0, 2'h1, 8'h22, 8'h41, 1'b1, 1'b0);
        match_case(1'b0, 2'h2, 8'h22, 8'h22, 1'b1, 1'b1);
        match_case(1'b0, 2'h2, 8'h22, 8'h40, 1'b1, 1'b1);
        match_case(1'b0, 2'h2, 8'h22, 8'h41, 1'b1, 1'b0);
        match_case(1'b0, 2'h2, 8'h22, 8'h21, 1'b1, 1'b0);
        match_case(1'b0, 2'h3, 8'h40, 8'h40, 1'b1, 1'b0);
        match_case(1'b1, 2'h1, 8'h22, 8'h22, 1'b0, 1'b0);
        @(posedge core_clk);
        addressed_frame <= 1'b0;
        match_case(1'b0, 2'h0, 8'h0f, 8'h4a, 1'b0, 1'b0);
        @(posedge core_clk);
        addressed_frame <= 1'b1;
        $display("match done");
    endtask : t_match

    task automatic t_tx();
        @(posedge core_clk);
        master_mode <= 1'b0;
        wr(OFS_CONTROL_WORD_B, 32'h40);
        wr(OFS_DATA, 32'h05a);
        chk1(preload_stb, 1'b1);
        chk1(tx_valid, 1'b0);
        @(posedge core_clk);
        master_mode <= 1'b1;
        wr(OFS_CONTROL_WORD_B, 32'h2000);
        wr(OFS_DATA, 32'h1a5);
        chk1(preload_stb, 1'b0);
        chk32({23'h0, tx_data}, 32'h0a5);
        settle();
        chk1(ss_oe_n, 1'b0);
        chk1(ss_out, 1'b0);
        rchk(OFS_IRQ_FLAGS, 32'h00);
        far.shift_out();
        rchk(OFS_IRQ_FLAGS, 32'h03);
        chk1(ss_oe_n, 1'b0);
        chk1(ss_out, 1'b1);
        wr(OFS_IRQ_FLAGS, 32'h02);
        rchk(OFS_IRQ_FLAGS, 32'h01);
        wr(OFS_CONTROL_WORD_B, 32'h1);
        wr(OFS_DATA, 32'h1a5);
        chk32({23'h0, tx_data}, 32'h1a5);
        settle();
        chk1(ss_oe_n, 1'b1);
        far.shift_out();
        rchk(OFS_IRQ_FLAGS, 32'h03);
        wr(OFS_DATA, 32'h000);
        rchk(OFS_IRQ_FLAGS, 32'h00);
        $display("transmit done");
    endtask : t_tx

    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : summarize

    initial begin
        nrst = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        master_mode = 1'b0;
        addressed_frame = 1'b1;
        match_address = 8'h40;
        match_mask_or_second_value = 8'h00;
        repeat (16) @(posedge core_clk);
        nrst <= 1'b1;
        t_regs();
        t_enables();
        t_ssl(1'b1, 32'h09);
        t_ssl(1'b0, 32'h01);
        t_rx();
        t_match();
        t_tx();
        summarize();
    end

    initial begin
        #200000;
        error_cnt++;
        $display("BAD t=%0t watchdog expired", $time);
        summarize();
    end
endmodule : tb_sci_top
`default_nettype wire
